// *** design/cid_core.sv ***
// operand addressing, opcode fetch, stack push and condition-code core
`include "cid_map.svh"
module cid_core (
    input  wire logic                 clk,
    input  wire logic                 resetn,
    input  wire logic                 opcode_in_valid,
    input  wire logic [7:0]           opcode_in,
    input  wire logic                 pc_load,
    input  wire logic [15:0]          pc_value,
    input  wire logic                 req_valid,
    input  cid_pkg::cid_req_type      req,
    input  wire logic [7:0]           acc_a,
    input  wire logic [7:0]           acc_b,
    input  wire logic [15:0]          idx_x,
    input  wire logic [15:0]          idx_y,
    input  wire logic                 rd_ack,
    input  wire logic [7:0]           rd_data,
    input  wire logic                 push_valid,
    input  wire logic [15:0]          push_word,
    input  wire logic                 ccr_write,
    input  wire logic [7:0]           ccr_wdata,
    input  wire logic                 alu_valid,
    input  cid_pkg::cid_alu_type      alu_op,
    input  wire logic [7:0]           alu_a,
    input  wire logic [7:0]           alu_b,
    input  wire logic                 stop_request,
    input  wire logic                 nonmaskable_external_interrupt_pin,
    input  wire logic                 irq_request,
    output logic                      req_ready,
    output logic                      ea_valid,
    output logic [15:0]               ea,
    output cid_pkg::cid_ext_type      ext_count,
    output logic                      mode_illegal,
    output logic                      wb_valid,
    output cid_pkg::cid_base_type     wb_sel,
    output logic [15:0]               wb_value,
    output logic                      rd_req,
    output logic [15:0]               rd_addr,
    output logic                      push_ready,
    output logic                      push_wr,
    output logic [15:0]               push_addr,
    output logic [7:0]                push_data,
    output logic                      opcode_valid,
    output logic [7:0]                opcode_out,
    output logic                      opcode_page2,
    output logic [15:0]               stack_pointer,
    output logic [15:0]               program_counter,
    output logic [7:0]                condition_code_register,
    output logic [7:0]                alu_result,
    output logic                      stop_entered,
    output logic                      nmi_taken,
    output logic                      irq_taken
);
    cid_pkg::cid_dec_type  dec;
    cid_pkg::cid_state_type state;
    logic [15:0]           ptr_addr;
    logic [7:0]            ptr_hi;
    logic [7:0]            push_hold;
    logic                  page2_pending;

    cid_postbyte_decode u_dec (
        .index_postbyte  (req.index_postbyte),
        .ext_hi          (req.ext_hi),
        .ext_lo          (req.ext_lo),
        .acc_a           (acc_a),
        .acc_b           (acc_b),
        .idx_x           (idx_x),
        .idx_y           (idx_y),
        .stack_pointer   (stack_pointer),
        .program_counter (program_counter),
        .dec             (dec)
    );

    // request acceptance and mode split
    wire req_take  = req_valid && req_ready;
    wire is_index  = (req.mode == cid_pkg::CID_MODE_INDEXED);
    wire is_direct = (req.mode == cid_pkg::CID_MODE_DIRECT);
    wire take_ind  = req_take && is_index && dec.indirect && !dec.illegal;
    wire take_auto = req_take && is_index && dec.auto_upd && !dec.illegal;
    wire [15:0] plain_ea = is_direct ? {8'h00, req.ext_hi}
                         : is_index ? dec.ea : {req.ext_hi, req.ext_lo};
    wire push_start = push_valid && push_ready;
    wire sp_from_wb = take_auto && (dec.base_sel == cid_pkg::CID_BASE_SP) && !push_start && push_ready;

    // pointer fetch sequencer for the indirect forms, high byte first
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state     <= cid_pkg::CID_ST_IDLE;
            req_ready <= 1'b1;
            rd_req    <= 1'b0;
            rd_addr   <= 16'h0000;
            ptr_addr  <= 16'h0000;
            ptr_hi    <= 8'h00;
        end
        else
        begin
            rd_req <= 1'b0;
            case (state)
                cid_pkg::CID_ST_IDLE:
                begin
                    if (take_ind)
                    begin
                        state     <= cid_pkg::CID_ST_PTR_HI;
                        req_ready <= 1'b0;
                        rd_req    <= 1'b1;
                        rd_addr   <= dec.ea;
                        ptr_addr  <= dec.ea;
                    end
                end
                cid_pkg::CID_ST_PTR_HI:
                begin
                    if (rd_ack)
                    begin
                        ptr_hi  <= rd_data;
                        rd_req  <= 1'b1;
                        rd_addr <= ptr_addr + 16'h0001;
                        state   <= cid_pkg::CID_ST_PTR_LO;
                    end
                end
                cid_pkg::CID_ST_PTR_LO:
                begin
                    if (rd_ack)
                    begin
                        state     <= cid_pkg::CID_ST_IDLE;
                        req_ready <= 1'b1;
                    end
                end
                default:
                begin
                    state     <= cid_pkg::CID_ST_IDLE;
                    req_ready <= 1'b1;
                end
            endcase
        end
    end

    // effective address result, one-cycle strobe
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ea_valid     <= 1'b0;
            ea           <= 16'h0000;
            ext_count    <= cid_pkg::indexed_short_mode;
            mode_illegal <= 1'b0;
        end
        else
        begin
            ea_valid     <= 1'b0;
            mode_illegal <= req_take && is_index && dec.illegal;
            if (state == cid_pkg::CID_ST_PTR_LO && rd_ack)
            begin
                ea_valid <= 1'b1;
                ea       <= {ptr_hi, rd_data};
            end
            else if (req_take && !(is_index && (dec.indirect || dec.illegal)))
            begin
                ea_valid <= 1'b1;
                ea       <= plain_ea;
            end
            if (req_take)
                ext_count <= is_index ? dec.ext_count : cid_pkg::indexed_short_mode;
        end
    end

    // auto modes hand the adjusted base back within the same instruction
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            wb_valid <= 1'b0;
            wb_sel   <= cid_pkg::CID_BASE_X;
            wb_value <= 16'h0000;
        end
        else
        begin
            wb_valid <= take_auto;
            if (take_auto)
            begin
                wb_sel   <= dec.base_sel;
                wb_value <= dec.wb_value;
            end
        end
    end

    // context push: low byte first so the high byte lands lower; the
    // stack pointer ends on the last byte written
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            stack_pointer <= `CID_SP_RESET;
            push_ready    <= 1'b1;
            push_wr       <= 1'b0;
            push_addr     <= 16'h0000;
            push_data     <= 8'h00;
            push_hold     <= 8'h00;
        end
        else
        begin
            push_wr <= 1'b0;
            if (push_start)
            begin
                push_ready    <= 1'b0;
                push_wr       <= 1'b1;
                push_addr     <= stack_pointer - 16'h0001;
                push_data     <= push_word[7:0];
                push_hold     <= push_word[15:8];
                stack_pointer <= stack_pointer - 16'h0001;
            end
            else if (!push_ready)
            begin
                push_ready    <= 1'b1;
                push_wr       <= 1'b1;
                push_addr     <= stack_pointer - 16'h0001;
                push_data     <= push_hold;
                stack_pointer <= stack_pointer - 16'h0001;
            end
            else if (sp_from_wb)
                stack_pointer <= dec.wb_value;
        end
    end

    // opcode fetch with second-page prefix
    wire is_prefix = (opcode_in == `CID_PAGE2_PREFIX) && !page2_pending;
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            program_counter <= `CID_PC_RESET;
            page2_pending   <= 1'b0;
            opcode_valid    <= 1'b0;
            opcode_out      <= 8'h00;
            opcode_page2    <= 1'b0;
        end
        else
        begin
            opcode_valid <= 1'b0;
            if (pc_load)
                program_counter <= pc_value;
            else if (opcode_in_valid)
                program_counter <= program_counter + 16'h0001;
            if (opcode_in_valid)
            begin
                page2_pending <= is_prefix;
                if (!is_prefix)
                begin
                    opcode_valid <= 1'b1;
                    opcode_out   <= opcode_in;
                    opcode_page2 <= page2_pending;
                end
            end
        end
    end

    // arithmetic and flags; 9-bit sums keep carry, nibble sums half-carry
    wire        c_in    = (alu_op == cid_pkg::CID_ALU_ADC) && condition_code_register[`CID_CCR_C];
    wire        is_sub  = (alu_op == cid_pkg::CID_ALU_SUB);
    wire        is_dadj = (alu_op == cid_pkg::CID_ALU_DEC_ADJUST);
    wire [8:0]  sum     = {1'b0, alu_a} + {1'b0, alu_b} + {8'h00, c_in};
    wire [4:0]  nib     = {1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]} + {4'h0, c_in};
    wire [8:0]  diff    = {1'b0, alu_a} - {1'b0, alu_b};
    wire        lo_adj  = condition_code_register[`CID_CCR_H] || (alu_a[3:0] > 4'h9);
    wire        hi_adj  = condition_code_register[`CID_CCR_C] || (alu_a > 8'h99);
    wire [7:0]  adj_res = alu_a + {hi_adj ? 4'h6 : 4'h0, lo_adj ? 4'h6 : 4'h0};
    wire [7:0]  res     = is_dadj ? adj_res : (is_sub ? diff[7:0] : sum[7:0]);
    wire        v_add   = (alu_a[7] == alu_b[7]) && (res[7] != alu_a[7]);
    wire        v_sub   = (alu_a[7] != alu_b[7]) && (res[7] != alu_a[7]);
    logic [7:0] next_ccr;

    always_comb
    begin
        next_ccr = ccr_write ? ccr_wdata : condition_code_register;
        if (alu_valid)
        begin
            next_ccr[`CID_CCR_N] = res[7];
            next_ccr[`CID_CCR_Z] = (res == 8'h00);
            if (is_dadj)
                next_ccr[`CID_CCR_C] = hi_adj || condition_code_register[`CID_CCR_C];
            else
            begin
                next_ccr[`CID_CCR_V] = is_sub ? v_sub : v_add;
                next_ccr[`CID_CCR_C] = is_sub ? diff[8] : sum[8];
                if (!is_sub)
                    next_ccr[`CID_CCR_H] = nib[4];
            end
        end
    end

    // condition codes, result and gated requests; masks act from the old value
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            condition_code_register <= `CID_CCR_RESET;
            alu_result              <= 8'h00;
            stop_entered            <= 1'b0;
            nmi_taken               <= 1'b0;
            irq_taken               <= 1'b0;
        end
        else
        begin
            condition_code_register <= next_ccr;
            if (alu_valid)
                alu_result <= res;
            stop_entered <= stop_request && !condition_code_register[`CID_CCR_S];
            nmi_taken    <= nonmaskable_external_interrupt_pin && !condition_code_register[`CID_CCR_X];
            irq_taken    <= irq_request && !condition_code_register[`CID_CCR_I];
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence push_lo_s;
        push_wr && !push_ready;
    endsequence
    sequence push_hi_s;
        push_wr && push_ready && (push_addr == $past(push_addr) - 16'h0001);
    endsequence

    stop_refuse_a: assert property (stop_request && condition_code_register[`CID_CCR_S] |=> !stop_entered)
        else $error("stop taken while disabled");
    nmi_mask_a: assert property (condition_code_register[`CID_CCR_X] |=> !nmi_taken)
        else $error("masked nonmaskable request taken");
    irq_mask_a: assert property (irq_request && !condition_code_register[`CID_CCR_I] |=> irq_taken)
        else $error("unmasked request not taken");
    direct_page_a: assert property (req_take && is_direct |=> ea_valid && ea == {8'h00, $past(req.ext_hi)})
        else $error("direct address high byte not zero");
    // rr=11 with bit 5 set is a long form, so the counter is never adjusted
    pc_auto_a: assert property (req_take && is_index && dec.base_sel == cid_pkg::CID_BASE_PC && !dec.indirect
                                |=> ea_valid && !wb_valid && !mode_illegal)
        else $error("program counter base refused or adjusted");
    zero_flag_a: assert property (alu_valid && !ccr_write
                                  |=> condition_code_register[`CID_CCR_Z] == (alu_result == 8'h00))
        else $error("zero flag disagrees with result");
    half_carry_a: assert property (alu_valid && alu_op == cid_pkg::CID_ALU_ADD_B_TO_A
                                   |=> condition_code_register[`CID_CCR_H] == $past(nib[4]))
        else $error("half carry wrong");
    push_order_a: assert property (push_start |=> push_lo_s ##1 push_hi_s)
        else $error("push byte order wrong");
    ptr_fetch_a: assert property (take_ind |=> rd_req && rd_addr == $past(dec.ea) && !req_ready)
        else $error("indirect pointer read not issued");
    page2_a: assert property (opcode_in_valid && is_prefix |=> !opcode_valid && page2_pending)
        else $error("prefix byte passed as opcode");
endmodule : cid_core

// *** design/cid_map.svh ***
// constants for the operand addressing and condition-code core
`ifndef CID_MAP_SVH
`define CID_MAP_SVH
`define CID_PAGE2_PREFIX 8'h18
`define CID_CCR_RESET    8'hD0
`define CID_CCR_S        7
`define CID_CCR_X        6
`define CID_CCR_H        5
`define CID_CCR_I        4
`define CID_CCR_N        3
`define CID_CCR_Z        2
`define CID_CCR_V        1
`define CID_CCR_C        0
`define CID_SP_RESET     16'h0000
`define CID_PC_RESET     16'h0000
`endif

// *** design/cid_pkg.sv ***
// types shared by the addressing core and the postbyte decoder
package cid_pkg;
    typedef enum logic [1:0] {
        CID_BASE_X  = 2'b00,
        CID_BASE_Y  = 2'b01,
        CID_BASE_SP = 2'b10,
        CID_BASE_PC = 2'b11
    } cid_base_type;

    typedef enum logic [1:0] {
        CID_MODE_DIRECT   = 2'b00,
        CID_MODE_EXTENDED = 2'b01,
        CID_MODE_INDEXED  = 2'b10
    } cid_mode_type;

    typedef enum logic [1:0] {
        indexed_short_mode   = 2'b00,
        indexed_one_ext_mode = 2'b01,
        indexed_two_ext_mode = 2'b10
    } cid_ext_type;

    typedef enum logic [2:0] {
        CID_ALU_ADD  = 3'b000,
        CID_ALU_ADC  = 3'b001,
        CID_ALU_ADD_B_TO_A = 3'b010,
        CID_ALU_SUB        = 3'b011,
        CID_ALU_DEC_ADJUST = 3'b100
    } cid_alu_type;

    typedef enum logic [1:0] {
        CID_ST_IDLE   = 2'b00,
        CID_ST_PTR_HI = 2'b01,
        CID_ST_PTR_LO = 2'b10
    } cid_state_type;

    typedef struct packed {
        cid_mode_type mode;
        logic [7:0]   index_postbyte;
        logic [7:0]   ext_hi;
        logic [7:0]   ext_lo;
    } cid_req_type;

    typedef struct packed {
        cid_base_type base_sel;
        logic [15:0]  ea;
        logic [15:0]  wb_value;
        cid_ext_type  ext_count;
        logic         auto_upd;
        logic         indirect;
        logic         illegal;
    } cid_dec_type;

    // base register pick, used only by the postbyte decoder
    function automatic logic [15:0] cid_base_value(input cid_base_type sel, input logic [15:0] x,
                                                   input logic [15:0] y, input logic [15:0] sp,
                                                   input logic [15:0] pc);
        case (sel)
            CID_BASE_X:  return x;
            CID_BASE_Y:  return y;
            CID_BASE_SP: return sp;
            default:     return pc;
        endcase
    endfunction : cid_base_value
endpackage : cid_pkg

// *** design/cid_postbyte_decode.sv ***
// combinational decoder of the indexed postbyte and its extension bytes
module cid_postbyte_decode (
    input  wire logic [7:0]          index_postbyte,
    input  wire logic [7:0]          ext_hi,
    input  wire logic [7:0]          ext_lo,
    input  wire logic [7:0]          acc_a,
    input  wire logic [7:0]          acc_b,
    input  wire logic [15:0]         idx_x,
    input  wire logic [15:0]         idx_y,
    input  wire logic [15:0]         stack_pointer,
    input  wire logic [15:0]         program_counter,
    output cid_pkg::cid_dec_type     dec
);
    // form classification
    wire               is_long  = (index_postbyte[7:5] == 3'b111);
    wire               is_auto  = !is_long && index_postbyte[5];
    wire [1:0]         sel_raw  = is_long ? index_postbyte[4:3] : index_postbyte[7:6];
    wire cid_pkg::cid_base_type sel = cid_pkg::cid_base_type'(sel_raw);
    wire [15:0]        base     = cid_pkg::cid_base_value(sel, idx_x, idx_y, stack_pointer, program_counter);

    // offsets of each form; extension bytes arrive high byte first
    wire [15:0] off5   = {{11{index_postbyte[4]}}, index_postbyte[4:0]};
    wire [15:0] step   = index_postbyte[3] ? {12'hFFF, index_postbyte[3:0]}
                                           : {12'h000, index_postbyte[3:0]} + 16'h0001;
    wire [15:0] off9   = {{8{index_postbyte[0]}}, ext_hi};
    wire [15:0] off16  = {ext_hi, ext_lo};
    wire [15:0] acc_d  = {acc_a, acc_b};
    wire [15:0] off_acc = (index_postbyte[1:0] == 2'b00) ? {8'h00, acc_a}
                        : (index_postbyte[1:0] == 2'b01) ? {8'h00, acc_b} : acc_d;
    wire [15:0] off_const = index_postbyte[1] ? off16 : off9;
    wire [15:0] offset = !is_long ? off5 : (index_postbyte[2] ? off_acc : off_const);
    wire [15:0] adjusted = base + step;

    // address: pre forms use adjusted base, post forms the old base
    assign dec.base_sel  = sel;
    assign dec.ea        = is_auto ? (index_postbyte[4] ? base : adjusted) : base + offset;
    assign dec.wb_value  = adjusted;
    assign dec.auto_upd  = is_auto;
    assign dec.indirect  = is_long && (index_postbyte[1:0] == 2'b11);
    assign dec.illegal   = is_auto && (sel == cid_pkg::CID_BASE_PC);
    assign dec.ext_count = (!is_long || index_postbyte[2]) ? cid_pkg::indexed_short_mode
                         : (index_postbyte[1] ? cid_pkg::indexed_two_ext_mode
                                              : cid_pkg::indexed_one_ext_mode);
endmodule : cid_postbyte_decode

// *** testbench/cpu_indexed_address_decode_test.sv ***
// directed bench for the addressing and condition-code core
module cpu_indexed_address_decode_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, resetn = 0, opcode_in_valid = 0, pc_load = 0, req_valid = 0, rd_ack = 0, push_valid = 0;
    logic ccr_write = 0, alu_valid = 0, stop_request = 0, nonmaskable_external_interrupt_pin = 0, irq_request = 0;
    logic [7:0] opcode_in = 8'h00, acc_a = 8'h80, acc_b = 8'h01, rd_data = 8'h00, ccr_wdata = 8'h00;
    logic [7:0] alu_a = 8'h00, alu_b = 8'h00, push_data, opcode_out, condition_code_register, alu_result;
    logic [15:0] pc_value = 16'h4000, idx_x = 16'h1000, idx_y = 16'h2000, push_word = 16'h1234;
    logic [15:0] ea, wb_value, rd_addr, push_addr, stack_pointer, program_counter;
    logic req_ready, ea_valid, mode_illegal, wb_valid, rd_req, push_ready, push_wr, opcode_valid;
    logic opcode_page2, stop_entered, nmi_taken, irq_taken;
    cid_pkg::cid_req_type req = '0;
    cid_pkg::cid_alu_type alu_op = cid_pkg::CID_ALU_ADD;
    cid_pkg::cid_ext_type ext_count;
    cid_pkg::cid_base_type wb_sel;
    int err_total = 0, total_checks = 0, cyc = 0;

    cid_core dut_u (.clk, .resetn, .opcode_in_valid, .opcode_in, .pc_load, .pc_value, .req_valid, .req, .acc_a,
        .acc_b, .idx_x, .idx_y, .rd_ack, .rd_data, .push_valid, .push_word, .ccr_write, .ccr_wdata, .alu_valid,
        .alu_op, .alu_a, .alu_b, .stop_request, .nonmaskable_external_interrupt_pin, .irq_request, .req_ready,
        .ea_valid, .ea, .ext_count, .mode_illegal, .wb_valid, .wb_sel, .wb_value, .rd_req, .rd_addr, .push_ready,
        .push_wr, .push_addr, .push_data, .opcode_valid, .opcode_out, .opcode_page2, .stack_pointer,
        .program_counter, .condition_code_register, .alu_result, .stop_entered, .nmi_taken, .irq_taken);

    // free-running clock and a hang guard well above the run length
    always #5 clk = ~clk;
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            err_total++;
            give_verdict();
        end
    end

    task give_verdict;
        if (err_total == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : give_verdict

    task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // inputs always move 1 ns after the edge
    task tick;
        @(posedge clk);
        #1;
    endtask : tick

    // one address request; pointer bytes answered AB then CD
    task addr(input logic [1:0] m, input logic [7:0] pb, hi, lo, input logic [15:0] exp_ea, ptr,
              input logic [1:0] ext, input logic ill);
        int k;
        int r;
        // one idle edge so the strobe is never lowered and raised in one step
        tick;
        r = 0;
        req = {m, pb, hi, lo};
        req_valid = 1;
        tick;
        req_valid = 0;
        for (k = 0; k < 12 && !ea_valid && !mode_illegal; k++)
        begin
            rd_ack = (rd_req === 1'b1);
            if (rd_ack)
            begin
                chk("rd_addr", ptr + r[15:0], rd_addr);
                rd_data = (r == 0) ? 8'hAB : 8'hCD;
                r++;
            end
            tick;
        end
        rd_ack = 0;
        chk("mode_illegal", {15'h0, ill}, {15'h0, mode_illegal});
        chk("ea_valid", {15'h0, !ill}, {15'h0, ea_valid});
        if (!ill)
        begin
            chk("ea", exp_ea, ea);
            chk("ext_count", {14'h0, ext}, {14'h0, ext_count});
        end
    endtask : addr

    task alu_t(input cid_pkg::cid_alu_type op, input logic [7:0] a, b, res, flags);
        tick;
        alu_valid = 1;
        alu_op = op;
        alu_a = a;
        alu_b = b;
        tick;
        alu_valid = 0;
        chk("alu_result", {8'h0, res}, {8'h0, alu_result});
        chk("flags", {8'h0, flags}, {8'h0, condition_code_register & 8'h2F});
    endtask : alu_t

    initial
    begin
        repeat (8) @(posedge clk);
        #1 resetn = 1;
        chk("ccr", 16'h00D0, {8'h0, condition_code_register});
        chk("sp", 16'h0000, stack_pointer);
        addr(2, 8'h1F, 8'h00, 8'h00, 16'h0FFF, 16'h0, 0, 0);
        addr(2, 8'h50, 8'h00, 8'h00, 16'h1FF0, 16'h0, 0, 0);
        addr(2, 8'h81, 8'h00, 8'h00, 16'h0001, 16'h0, 0, 0);
        addr(2, 8'hE1, 8'hFF, 8'h00, 16'h0FFF, 16'h0, 1, 0);
        addr(2, 8'hE0, 8'hFF, 8'h00, 16'h10FF, 16'h0, 1, 0);
        addr(2, 8'hE2, 8'h12, 8'h34, 16'h2234, 16'h0, 2, 0);
        addr(2, 8'hE3, 8'h12, 8'h34, 16'hABCD, 16'h2234, 2, 0);
        addr(2, 8'hE4, 8'h00, 8'h00, 16'h1080, 16'h0, 0, 0);
        addr(2, 8'hE5, 8'h00, 8'h00, 16'h1001, 16'h0, 0, 0);
        addr(2, 8'hE6, 8'h00, 8'h00, 16'h9001, 16'h0, 0, 0);
        addr(2, 8'hE7, 8'h00, 8'h00, 16'hABCD, 16'h9001, 0, 0);
        addr(0, 8'h00, 8'h5A, 8'h77, 16'h005A, 16'h0, 0, 0);
        addr(1, 8'h00, 8'h5A, 8'h77, 16'h5A77, 16'h0, 0, 0);
        addr(2, 8'h30, 8'h00, 8'h00, 16'h1000, 16'h0, 0, 0);
        chk("wb_value", 16'h1001, wb_value);
        addr(2, 8'h67, 8'h00, 8'h00, 16'h2008, 16'h0, 0, 0);
        chk("wb_sel", 16'h0001, {14'h0, wb_sel});
        addr(2, 8'hF8, 8'h10, 8'h00, 16'h0010, 16'h0, 1, 0);
        chk("wb_valid", 16'h0, {15'h0, wb_valid});
        pc_load = 1;
        tick;
        pc_load = 0;
        addr(2, 8'hC0, 8'h00, 8'h00, 16'h4000, 16'h0, 0, 0);
        push_valid = 1;
        tick;
        push_valid = 0;
        chk("push_wr", 16'h0001, {15'h0, push_wr});
        chk("push_addr", 16'hFFFF, push_addr);
        chk("push_lo", 16'h0034, {8'h0, push_data});
        tick;
        chk("push_wr", 16'h0001, {15'h0, push_wr});
        chk("push_addr", 16'hFFFE, push_addr);
        chk("push_hi", 16'h0012, {8'h0, push_data});
        chk("sp", 16'hFFFE, stack_pointer);
        opcode_in_valid = 1;
        opcode_in = 8'h18;
        tick;
        opcode_in = 8'h20;
        tick;
        opcode_in_valid = 0;
        chk("page2", 16'h0120, {7'h0, opcode_valid & opcode_page2, opcode_out});
        chk("pc", 16'h4002, program_counter);
        alu_t(cid_pkg::CID_ALU_ADD, 8'h08, 8'h08, 8'h10, 8'h20);
        alu_t(cid_pkg::CID_ALU_ADD, 8'h80, 8'h80, 8'h00, 8'h07);
        alu_t(cid_pkg::CID_ALU_SUB, 8'h00, 8'h01, 8'hFF, 8'h09);
        alu_t(cid_pkg::CID_ALU_ADC, 8'h01, 8'h01, 8'h03, 8'h00);
        alu_t(cid_pkg::CID_ALU_ADD_B_TO_A, 8'h0F, 8'h01, 8'h10, 8'h20);
        alu_t(cid_pkg::CID_ALU_DEC_ADJUST, 8'h10, 8'h00, 8'h16, 8'h20);
        {stop_request, nonmaskable_external_interrupt_pin, irq_request} = 3'b111;
        tick;
        chk("gated", 16'h0, {13'h0, stop_entered, nmi_taken, irq_taken});
        ccr_write = 1;
        tick;
        ccr_write = 0;
        tick;
        chk("ungated", 16'h0007, {13'h0, stop_entered, nmi_taken, irq_taken});
        give_verdict();
    end
endmodule : cpu_indexed_address_decode_test
